// ==== include/tidr_pkg.sv ====
// Constants and types for the thread id and array debug register bank
package tidr_pkg;

  // Coprocessor register selectors
  localparam logic [3:0] TIDR_CRN_ID = 4'hD;
  localparam logic [3:0] TIDR_CRN_DBG = 4'hF;
  localparam logic [2:0] TIDR_OP1 = 3'h0;
  localparam logic [3:0] TIDR_CRM_ID = 4'h0;
  localparam logic [2:0] TIDR_OP2_URW = 3'h2;
  localparam logic [2:0] TIDR_OP2_URO = 3'h3;
  localparam logic [2:0] TIDR_OP2_PRIV = 3'h4;

  // Debug data register selection: secondary picks side, opcode2 picks word
  localparam logic [3:0] TIDR_CRM_DSIDE = 4'h0;
  localparam logic [3:0] TIDR_CRM_ISIDE = 4'h1;
  localparam logic [3:0] TIDR_CRM_LAST = 4'h3;
  localparam logic [2:0] TIDR_OP2_LO = 3'h0;
  localparam logic [2:0] TIDR_OP2_HI = 3'h1;

  // Array operation kinds, coded as opcode2
  localparam logic [2:0] TIDR_OP2_CAM = 3'h2;
  localparam logic [2:0] TIDR_OP2_ATTRIBUTE_ARRAY = 3'h3;
  localparam logic [2:0] TIDR_OP2_PA = 3'h4;
  localparam logic [2:0] TIDR_OP2_HAB = 3'h5;
  localparam logic [2:0] TIDR_OP2_TAG = 3'h6;

  // Live bits of each array entry
  localparam logic [31:0] TIDR_MASK_CAM_LO = 32'hFFFFFFFF;
  localparam logic [31:0] TIDR_MASK_CAM_HI = 32'h0000001F;
  localparam logic [31:0] TIDR_MASK_ATTRIBUTE_ARRAY = 32'h00000FFF;
  localparam logic [31:0] TIDR_MASK_PA = 32'h1FFFFFFF;
  localparam logic [31:0] TIDR_MASK_HAB = 32'h000000FF;
  localparam logic [31:0] TIDR_MASK_TAG = 32'h007FFFFF;
  localparam logic [31:0] TIDR_MASK_NONE = 32'h00000000;

  // Reset values
  localparam logic [31:0] TIDR_ID_RST = 32'h00000000;
  localparam logic [31:0] TIDR_DREG_RST = 32'h00000000;
  localparam int TIDR_NUM_ID = 3;

  typedef enum logic [0:0] {
    TIDR_ST_IDLE = 1'b0,
    TIDR_ST_WAIT = 1'b1
  } tidr_state_e;

endpackage

// ==== design/tidr_core.sv ====
// Thread and process id registers and level-one array debug data registers
`timescale 1ns/1ns
`default_nettype none

module tidr_core
  import tidr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Coprocessor transfer from the pipeline
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [2:0] req_op1_i,
  input wire logic [3:0] req_crn_i,
  input wire logic [3:0] req_crm_i,
  input wire logic [2:0] req_op2_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic secure_i,
  input wire logic privileged_i,
  output logic resp_valid_o,
  output logic resp_undef_o,
  output logic [31:0] resp_rdata_o,
  // Array access port toward the level-one arrays
  output logic arr_req_o,
  output logic arr_write_o,
  output logic arr_iside_o,
  output logic [2:0] arr_kind_o,
  output logic [31:0] arr_index_o,
  output logic [31:0] arr_wdata_lo_o,
  output logic [31:0] arr_wdata_hi_o,
  input wire logic arr_rvalid_i,
  input wire logic [31:0] arr_rdata_lo_i,
  input wire logic [31:0] arr_rdata_hi_i
);

  typedef struct packed {
    tidr_state_e fsm;
    logic [1:0][TIDR_NUM_ID-1:0][31:0] id;
    logic [1:0][31:0] lo;
    logic [1:0][31:0] hi;
    logic resp_valid;
    logic resp_undef;
    logic [31:0] rdata;
    logic arr_req;
    logic arr_write;
    logic arr_iside;
    logic [2:0] arr_kind;
    logic [31:0] arr_index;
    logic [31:0] arr_wlo;
    logic [31:0] arr_whi;
  } tidr_state_s;

  tidr_state_s r;
  tidr_state_s next_r;

  // Live low-word bits for an array kind
  function automatic logic [31:0] tidr_lo_mask(input logic [2:0] kind);
    case (kind)
      TIDR_OP2_CAM: tidr_lo_mask = TIDR_MASK_CAM_LO;
      TIDR_OP2_ATTRIBUTE_ARRAY: tidr_lo_mask = TIDR_MASK_ATTRIBUTE_ARRAY;
      TIDR_OP2_PA: tidr_lo_mask = TIDR_MASK_PA;
      TIDR_OP2_HAB: tidr_lo_mask = TIDR_MASK_HAB;
      TIDR_OP2_TAG: tidr_lo_mask = TIDR_MASK_TAG;
      default: tidr_lo_mask = TIDR_MASK_NONE;
    endcase
  endfunction

  // Only the CAM entry spills into the high word
  function automatic logic [31:0] tidr_hi_mask(input logic [2:0] kind);
    tidr_hi_mask = (kind == TIDR_OP2_CAM) ? TIDR_MASK_CAM_HI : TIDR_MASK_NONE;
  endfunction

  logic take;
  logic id_hit;
  logic id_ok;
  logic [1:0] id_idx;
  logic dreg_hit;
  logic arr_hit;
  logic sec_priv;
  logic [31:0] id_rd_val;

  assign req_ready_o = (r.fsm == TIDR_ST_IDLE);
  assign take = req_valid_i && req_ready_o;
  assign sec_priv = secure_i && privileged_i;
  assign id_idx = 2'(req_op2_i - TIDR_OP2_URW);

  always_comb begin
    id_hit = (req_op1_i == TIDR_OP1) && (req_crn_i == TIDR_CRN_ID)
      && (req_crm_i == TIDR_CRM_ID)
      && (req_op2_i >= TIDR_OP2_URW) && (req_op2_i <= TIDR_OP2_PRIV);
    unique case (req_op2_i)
      TIDR_OP2_URW: id_ok = 1'b1;
      TIDR_OP2_URO: id_ok = privileged_i || !req_write_i;
      default: id_ok = privileged_i;
    endcase
    dreg_hit = (req_op1_i == TIDR_OP1) && (req_crn_i == TIDR_CRN_DBG)
      && (req_crm_i <= TIDR_CRM_ISIDE) && (req_op2_i <= TIDR_OP2_HI);
    // Array operations are only issued as register-to-coprocessor moves
    arr_hit = (req_op1_i == TIDR_OP1) && (req_crn_i == TIDR_CRN_DBG) && req_write_i
      && (req_crm_i <= TIDR_CRM_LAST)
      && (req_op2_i >= TIDR_OP2_CAM) && (req_op2_i <= TIDR_OP2_TAG);
    id_rd_val = r.id[secure_i][id_idx];
  end

  always_comb begin
    next_r = r;
    next_r.resp_valid = 1'b0;
    next_r.resp_undef = 1'b0;
    next_r.arr_req = 1'b0;
    unique case (r.fsm)
      TIDR_ST_IDLE: begin
        if (take) begin
          next_r.resp_valid = 1'b1;
          next_r.rdata = 32'h00000000;
          if (id_hit && id_ok) begin
            // Plain storage, bank chosen by current security state
            if (req_write_i) begin
              next_r.id[secure_i][id_idx] = req_wdata_i;
            end else begin
              next_r.rdata = id_rd_val;
            end
          end else if (dreg_hit && sec_priv) begin
            if (req_write_i) begin
              if (req_op2_i == TIDR_OP2_LO) begin
                next_r.lo[req_crm_i[0]] = req_wdata_i;
              end else begin
                next_r.hi[req_crm_i[0]] = req_wdata_i;
              end
            end else begin
              next_r.rdata = (req_op2_i == TIDR_OP2_LO) ? r.lo[req_crm_i[0]]
                : r.hi[req_crm_i[0]];
            end
          end else if (arr_hit && sec_priv) begin
            next_r.arr_req = 1'b1;
            next_r.arr_write = !req_crm_i[1];
            next_r.arr_iside = req_crm_i[0];
            next_r.arr_kind = req_op2_i;
            next_r.arr_index = req_wdata_i;
            // Reserved bits never reach the array
            next_r.arr_wlo = r.lo[req_crm_i[0]] & tidr_lo_mask(req_op2_i);
            next_r.arr_whi = r.hi[req_crm_i[0]] & tidr_hi_mask(req_op2_i);
            if (req_crm_i[1]) begin
              // Answer held back until the array returns the entry
              next_r.resp_valid = 1'b0;
              next_r.fsm = TIDR_ST_WAIT;
            end
          end else begin
            next_r.resp_undef = 1'b1;
          end
        end
      end
      TIDR_ST_WAIT: begin
        if (arr_rvalid_i) begin
          next_r.resp_valid = 1'b1;
          next_r.fsm = TIDR_ST_IDLE;
          // Reserved low-word bits read back as zero; the high word is reloaded only for a CAM entry
          next_r.lo[r.arr_iside] = arr_rdata_lo_i & tidr_lo_mask(r.arr_kind);
          if (r.arr_kind == TIDR_OP2_CAM) begin
            next_r.hi[r.arr_iside] = arr_rdata_hi_i & TIDR_MASK_CAM_HI;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r.fsm <= TIDR_ST_IDLE;
      r.id <= {(2 * TIDR_NUM_ID){TIDR_ID_RST}};
      r.lo <= {2{TIDR_DREG_RST}};
      r.hi <= {2{TIDR_DREG_RST}};
      r.resp_valid <= 1'b0;
      r.resp_undef <= 1'b0;
      r.rdata <= 32'h00000000;
      r.arr_req <= 1'b0;
      r.arr_write <= 1'b0;
      r.arr_iside <= 1'b0;
      r.arr_kind <= 3'h0;
      r.arr_index <= 32'h00000000;
      r.arr_wlo <= 32'h00000000;
      r.arr_whi <= 32'h00000000;
    end else begin
      r <= next_r;
    end
  end

  assign resp_valid_o = r.resp_valid;
  assign resp_undef_o = r.resp_undef;
  assign resp_rdata_o = r.rdata;
  assign arr_req_o = r.arr_req;
  assign arr_write_o = r.arr_write;
  assign arr_iside_o = r.arr_iside;
  assign arr_kind_o = r.arr_kind;
  assign arr_index_o = r.arr_index;
  assign arr_wdata_lo_o = r.arr_wlo;
  assign arr_wdata_hi_o = r.arr_whi;

  default clocking tidr_cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  user_urw_ok_a: assert property (
    take && id_hit && req_op2_i == TIDR_OP2_URW && !privileged_i
    |=> resp_valid_o && !resp_undef_o)
    else $error("user access to read/write id register refused");

  // Back-to-back requests are legal, so only the answer cycle is judged
  user_uro_write_a: assert property (
    take && id_hit && req_op2_i == TIDR_OP2_URO && req_write_i && !privileged_i
    |=> resp_valid_o && resp_undef_o)
    else $error("user write to read-only id register not undefined");

  user_uro_read_a: assert property (
    take && id_hit && req_op2_i == TIDR_OP2_URO && !req_write_i && !privileged_i
    |=> resp_valid_o && !resp_undef_o)
    else $error("user read of read-only id register refused");

  user_priv_undef_a: assert property (
    take && id_hit && req_op2_i == TIDR_OP2_PRIV && !privileged_i
    |=> resp_valid_o && resp_undef_o)
    else $error("user access to privileged id register not undefined");

  priv_id_ok_a: assert property (
    take && id_hit && privileged_i |=> resp_valid_o && !resp_undef_o)
    else $error("privileged id register access refused");

  id_bank_read_a: assert property (
    take && id_hit && id_ok && !req_write_i |=> resp_rdata_o == $past(id_rd_val))
    else $error("id register read returned wrong bank or value");

  id_write_store_a: assert property (
    take && id_hit && id_ok && req_write_i
    |=> r.id[$past(secure_i)][$past(id_idx)] == $past(req_wdata_i)
      && $stable(r.lo) && $stable(r.hi) && !arr_req_o)
    else $error("id register write not stored or had side effects");

  id_bank_keep_a: assert property (
    take && id_hit && id_ok && req_write_i
    |=> r.id[!$past(secure_i)] == $past(r.id[!secure_i]))
    else $error("id write disturbed the other security bank");

  op1_undef_a: assert property (
    take && req_op1_i != TIDR_OP1 |=> resp_valid_o && resp_undef_o)
    else $error("nonzero opcode1 access not undefined");

  undef_answer_a: assert property (
    resp_undef_o |-> resp_valid_o && resp_rdata_o == 32'h00000000)
    else $error("undefined answer without valid or with data");

  dbg_secure_only_a: assert property (
    take && req_crn_i == TIDR_CRN_DBG && !sec_priv
    |=> resp_undef_o && !arr_req_o)
    else $error("debug register reached outside secure privileged mode");

  undef_no_change_a: assert property (
    resp_undef_o |-> $stable(r.id) && $stable(r.lo) && $stable(r.hi) && !arr_req_o)
    else $error("undefined access changed state");

  dreg_lo_read_a: assert property (
    take && dreg_hit && sec_priv && !req_write_i && req_op2_i == TIDR_OP2_LO
    |=> resp_rdata_o == $past(r.lo[req_crm_i[0]]))
    else $error("debug low word read returned wrong value");

  dreg_hi_read_a: assert property (
    take && dreg_hit && sec_priv && !req_write_i && req_op2_i == TIDR_OP2_HI
    |=> resp_rdata_o == $past(r.hi[req_crm_i[0]]))
    else $error("debug high word read returned wrong value");

  dreg_lo_write_a: assert property (
    take && dreg_hit && sec_priv && req_write_i && req_op2_i == TIDR_OP2_LO
    |=> r.lo[$past(req_crm_i[0])] == $past(req_wdata_i) && $stable(r.id))
    else $error("debug low word write not stored");

  arr_write_answer_a: assert property (
    arr_req_o && arr_write_o |-> resp_valid_o && !resp_undef_o)
    else $error("array write not answered with the command");

  arr_wdata_src_a: assert property (
    take && arr_hit && sec_priv && !req_crm_i[1]
    |=> arr_req_o && arr_write_o && arr_index_o == $past(req_wdata_i)
      && arr_wdata_lo_o == ($past(r.lo[req_crm_i[0]]) & tidr_lo_mask(arr_kind_o)))
    else $error("array write did not carry the low debug word");

  arr_read_hold_a: assert property (
    arr_req_o && !arr_write_o |-> !req_ready_o && !resp_valid_o)
    else $error("array read answered before data returned");

  arr_read_done_a: assert property (
    r.fsm == TIDR_ST_WAIT && arr_rvalid_i
    |=> resp_valid_o && req_ready_o && r.lo[$past(r.arr_iside)]
      == ($past(arr_rdata_lo_i) & tidr_lo_mask($past(r.arr_kind))))
    else $error("array read data not captured into the low word");

  narrow_hi_keep_a: assert property (
    r.fsm == TIDR_ST_WAIT && arr_rvalid_i && r.arr_kind != TIDR_OP2_CAM
    |=> $stable(r.hi))
    else $error("narrow array read disturbed the high word");

  attribute_array_mask_a: assert property (
    arr_req_o && arr_kind_o == TIDR_OP2_ATTRIBUTE_ARRAY
    |-> (arr_wdata_lo_o & ~TIDR_MASK_ATTRIBUTE_ARRAY) == 32'h00000000 && arr_wdata_hi_o == 32'h00000000)
    else $error("attribute write carries reserved bits");

  pa_mask_a: assert property (
    arr_req_o && arr_kind_o == TIDR_OP2_PA
    |-> (arr_wdata_lo_o & ~TIDR_MASK_PA) == 32'h00000000 && arr_wdata_hi_o == 32'h00000000)
    else $error("physical-address write carries reserved bits");

  hab_mask_a: assert property (
    arr_req_o && arr_kind_o == TIDR_OP2_HAB
    |-> (arr_wdata_lo_o & ~TIDR_MASK_HAB) == 32'h00000000 && arr_wdata_hi_o == 32'h00000000)
    else $error("hashed address buffer write carries reserved bits");

  tag_mask_a: assert property (
    arr_req_o && arr_kind_o == TIDR_OP2_TAG
    |-> (arr_wdata_lo_o & ~TIDR_MASK_TAG) == 32'h00000000 && arr_wdata_hi_o == 32'h00000000)
    else $error("tag write carries reserved bits");

  cam_hi_capture_a: assert property (
    r.fsm == TIDR_ST_WAIT && arr_rvalid_i && r.arr_kind == TIDR_OP2_CAM
    |=> r.hi[$past(r.arr_iside)] == ($past(arr_rdata_hi_i) & TIDR_MASK_CAM_HI))
    else $error("CAM high word not captured");

  id_write_c: cover property (take && id_hit && id_ok && req_write_i);
  arr_read_c: cover property (arr_req_o && !arr_write_o ##[1:20] resp_valid_o);
  arr_write_c: cover property (arr_req_o && arr_write_o);
  undef_c: cover property (resp_undef_o);
  dreg_read_c: cover property (take && dreg_hit && sec_priv && !req_write_i);

endmodule

`default_nettype wire

// ==== bench/tidr_arr_model.sv ====
// Behavioural level-one arrays: one entry per side and kind
`timescale 1ns/1ns
`default_nettype none
module tidr_arr_model (
  input wire logic core_clk_i,
  input wire logic arr_req_i,
  input wire logic arr_write_i,
  input wire logic arr_iside_i,
  input wire logic [2:0] arr_kind_i,
  input wire logic [31:0] arr_wdata_lo_i,
  input wire logic [31:0] arr_wdata_hi_i,
  input wire logic [3:0] delay_i,
  output logic arr_rvalid_o,
  output logic [31:0] arr_rdata_lo_o,
  output logic [31:0] arr_rdata_hi_o
);
  logic [31:0] mem_lo [16];
  logic [31:0] mem_hi [16];
  logic [3:0] slot = 4'h0;
  int cnt = -1;
  initial begin
    arr_rvalid_o = 1'b0;
    arr_rdata_lo_o = 32'h0;
    arr_rdata_hi_o = 32'h0;
  end
  always @(posedge core_clk_i) begin
    arr_rvalid_o <= 1'b0;
    // Idle data toggles so a stale capture cannot match
    arr_rdata_lo_o <= ~arr_rdata_lo_o;
    arr_rdata_hi_o <= ~arr_rdata_hi_o;
    if (arr_req_i && arr_write_i) begin
      mem_lo[{arr_iside_i, arr_kind_i}] <= arr_wdata_lo_i;
      mem_hi[{arr_iside_i, arr_kind_i}] <= arr_wdata_hi_i;
    end else if (arr_req_i) begin
      slot <= {arr_iside_i, arr_kind_i};
      cnt <= int'(delay_i);
    end else if (cnt == 0) begin
      arr_rvalid_o <= 1'b1;
      arr_rdata_lo_o <= mem_lo[slot];
      arr_rdata_hi_o <= mem_hi[slot];
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the id and array debug register bank
`timescale 1ns/1ns
`default_nettype none
module testbench
  import tidr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wr = 1'b0, sec = 1'b0, priv = 1'b0;
  logic [3:0] crn = 4'h0, crm = 4'h0, dly = 4'h0;
  logic [2:0] op2 = 3'h0, op1 = 3'h0, ak;
  logic [31:0] wd = 32'h0, rq, ax, awl, awh, arl, arh;
  logic rdy, rv, ru, aq, aw, ai, arv;
  int err_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  tidr_core tidr_core_inst (.core_clk_i(clk), .sys_rst_i(rst), .req_valid_i(valid),
    .req_ready_o(rdy), .req_write_i(wr), .req_op1_i(op1), .req_crn_i(crn),
    .req_crm_i(crm), .req_op2_i(op2), .req_wdata_i(wd), .secure_i(sec), .privileged_i(priv),
    .resp_valid_o(rv), .resp_undef_o(ru), .resp_rdata_o(rq), .arr_req_o(aq), .arr_write_o(aw),
    .arr_iside_o(ai), .arr_kind_o(ak), .arr_index_o(ax), .arr_wdata_lo_o(awl),
    .arr_wdata_hi_o(awh), .arr_rvalid_i(arv), .arr_rdata_lo_i(arl), .arr_rdata_hi_i(arh));
  tidr_arr_model tidr_arr_model_inst (.core_clk_i(clk), .arr_req_i(aq), .arr_write_i(aw),
    .arr_iside_i(ai), .arr_kind_i(ak), .arr_wdata_lo_i(awl), .arr_wdata_hi_i(awh),
    .delay_i(dly), .arr_rvalid_o(arv), .arr_rdata_lo_o(arl), .arr_rdata_hi_o(arh));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One transfer; returns at the negedge of the answer cycle
  task automatic cp(input logic w, input logic [3:0] n, m, input logic [2:0] o,
    input logic [31:0] d, input logic s, p);
    int i;
    @(posedge clk);
    valid <= 1'b1; wr <= w; crn <= n; crm <= m; op2 <= o; wd <= d; sec <= s; priv <= p;
    @(posedge clk);
    valid <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (rv === 1'b1) break;
      chk("req_ready_o busy", 32'h0, 32'(rdy));
    end
    if (i == 40) begin
      chk("resp_valid_o", 32'h1, 32'h0);
      end_of_test();
    end
    chk("req_ready_o", 32'h1, 32'(rdy));
  endtask
  task automatic test_ids();
    logic [31:0] v;
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 2; s++) cp(1, TIDR_CRN_ID, 0, 3'(r + 2), 32'hA5000000 + 32'(r * 2 + s), s[0], 1);
      for (int s = 0; s < 2; s++) begin
        v = 32'hA5000000 + 32'(r * 2 + s);
        cp(0, TIDR_CRN_ID, TIDR_CRM_ID, 3'(r + 2), 32'h0, s[0], 1'b0);
        chk("user read undef", 32'(r == 2), 32'(ru));
        if (r < 2) chk("user read data", v, rq);
        cp(1, TIDR_CRN_ID, TIDR_CRM_ID, 3'(r + 2), 32'h0BADF00D, s[0], 1'b0);
        chk("user write undef", 32'(r != 0), 32'(ru));
        cp(0, TIDR_CRN_ID, TIDR_CRM_ID, 3'(r + 2), 32'h0, s[0], 1'b1);
        chk("id after user write", (r == 0) ? 32'h0BADF00D : v, rq);
      end
      for (int s = 0; s < 2; s++) cp(1, TIDR_CRN_ID, 0, 3'(r + 2), 32'h0, s[0], 1);
    end
    $display("test_ids done");
  endtask
  task automatic test_dbg();
    for (int k = 0; k < 4; k++) cp(1, TIDR_CRN_DBG, 4'(k / 2), 3'(k % 2), 32'hD0000000 + 32'(k), 1, 1);
    for (int k = 0; k < 4; k++) begin
      cp(1, TIDR_CRN_DBG, 4'(k / 2), 3'(k % 2), 32'hFFFFFFFF, 1'b0, 1'b1);
      chk("nonsecure undef", 32'h1, 32'(ru));
      cp(1, TIDR_CRN_DBG, 4'(k / 2), 3'(k % 2), 32'hFFFFFFFF, 1'b1, 1'b0);
      chk("user undef", 32'h1, 32'(ru));
      cp(0, TIDR_CRN_DBG, 4'(k / 2), 3'(k % 2), 32'h0, 1'b1, 1'b1);
      chk("debug read", 32'hD0000000 + 32'(k), rq);
    end
    cp(0, TIDR_CRN_DBG, 4'h2, TIDR_OP2_CAM, 32'h0, 1'b1, 1'b1);
    chk("read form of array op undef", 32'h1, 32'(ru));
    @(posedge clk) op1 <= 3'h1;
    cp(0, TIDR_CRN_ID, TIDR_CRM_ID, TIDR_OP2_URW, 32'h0, 1'b1, 1'b1);
    chk("opcode1 nonzero undef", 32'h1, 32'(ru));
    @(posedge clk) op1 <= 3'h0;
    $display("test_dbg done");
  endtask
  task automatic test_arr(input logic [2:0] kd, input logic [31:0] mk, input logic sd);
    logic [31:0] p, q, hm;
    p = 32'h9E3779B9;
    q = 32'h6C8E9CF5;
    hm = (kd == TIDR_OP2_CAM) ? TIDR_MASK_CAM_HI : 32'hFFFFFFFF;
    dly <= sd ? 4'h0 : 4'h9;
    cp(1, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_LO, p, 1, 1);
    cp(1, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_HI, q, 1, 1);
    cp(1, TIDR_CRN_DBG, {3'h0, sd}, kd, 32'h00C00000, 1, 1);
    chk("arr_req_o", 32'h3, 32'({aq, aw}));
    chk("arr_kind_side", {28'h0, kd, sd}, 32'({ak, ai}));
    chk("arr_index_o", 32'h00C00000, ax);
    chk("arr_wdata_lo_o", p & mk, awl);
    if (kd == TIDR_OP2_CAM) chk("arr_wdata_hi_o", q & hm, awh);
    cp(1, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_LO, ~p, 1, 1);
    if (kd == TIDR_OP2_CAM) cp(1, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_HI, ~q, 1, 1);
    cp(1, TIDR_CRN_DBG, {3'h1, sd}, kd, 32'h00C00000, 1, 1);
    cp(0, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_LO, 32'h0, 1, 1);
    chk("low word after array read", p & mk, rq & mk);
    cp(0, TIDR_CRN_DBG, {3'h0, sd}, TIDR_OP2_HI, 32'h0, 1, 1);
    chk("high word after array read", q & hm, rq & hm);
    $display("test_arr kind %0d side %0d done", kd, sd);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_ids();
    test_dbg();
    for (int sd = 0; sd < 2; sd++) begin
      test_arr(TIDR_OP2_CAM, TIDR_MASK_CAM_LO, sd[0]);
      test_arr(TIDR_OP2_ATTRIBUTE_ARRAY, TIDR_MASK_ATTRIBUTE_ARRAY, sd[0]);
      test_arr(TIDR_OP2_PA, TIDR_MASK_PA, sd[0]);
      test_arr(TIDR_OP2_HAB, TIDR_MASK_HAB, sd[0]);
      test_arr(TIDR_OP2_TAG, TIDR_MASK_TAG, sd[0]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
